// >>> verilog/drive_health_log_recorder.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module drive_health_log_recorder #(
  parameter int unsigned CYCLES_PER_MS = health_log_pkg::CYC_PER_MS,
  parameter logic [7:0] MON_OPCODE = 8'h01,
  parameter logic [15:0] MON_KEY = 16'h0001,
  parameter logic [7:0] SUB_ENABLE = 8'h01,
  parameter logic [7:0] SUB_DISABLE = 8'h02
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [10:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_cmd_valid,
  input wire health_log_pkg::ata_cmd_t i_cmd,
  input wire logic [3:0] i_dev_state,
  input wire logic i_sub_supported,
  input wire logic i_attr_rd_fail,
  input wire logic i_attr_wr_fail,
  output health_log_pkg::mon_resp_t o_resp,
  output logic o_mon_enabled,
  input wire logic i_err_valid,
  input wire health_log_pkg::ata_err_t i_err,
  input wire logic [15:0] i_power_on_hours,
  output logic o_err_ready,
  input wire logic i_st_valid,
  input wire health_log_pkg::st_result_t i_st,
  output logic o_st_ready,
  input wire logic i_sel_valid,
  input wire logic [63:0] i_sel_lba,
  input wire logic [15:0] i_sel_span,
  output logic o_sel_ready
);
  import health_log_pkg::*;

  wr_state_t st_q;
  wr_state_t st_d;
  logic [10:0] idx_q;
  logic [8:0] base_q;
  logic [2:0] err_ptr_q;
  logic [4:0] st_ptr_q;
  logic [3:0] state_q;
  logic mon_en_q;
  logic [7:0] job_q [0:JOB_BYTES-1];
  logic [7:0] pay_d [0:JOB_BYTES-1];
  ata_cmd_t hist_q [0:CMD_SLOTS-1];
  logic [31:0] ts_q [0:CMD_SLOTS-1];
  logic [10:0] scan_q;
  logic [8:0] scan_prev_q;
  logic [7:0] sum_q;
  logic [7:0] csum_q [0:1];
  logic [1:0] rd_sec_q;
  logic rd_csum_q;
  logic [7:0] rd_csum_val_q;
  logic [7:0] ram_a;
  logic [7:0] ram_b;
  logic [15:0] err_cnt;
  logic [31:0] ms_cnt;
  logic ms_tick;

  // Millisecond time base and counters
  event_counter #(.W(18), .MAX(18'(CYCLES_PER_MS - 1)), .SAT(1'b0)) u_prescale (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_inc(1'b1), .o_count(), .o_wrap(ms_tick));
  event_counter #(.W(32), .MAX(32'hffff_ffff), .SAT(1'b0)) u_ms (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_inc(ms_tick), .o_count(ms_cnt), .o_wrap());

  // Event acceptance, error first
  wire idle = (st_q == W_IDLE);
  assign o_err_ready = idle;
  assign o_st_ready = idle & !i_err_valid;
  assign o_sel_ready = idle & !i_err_valid & !i_st_valid;
  wire take_err = i_err_valid & o_err_ready;
  wire take_st = i_st_valid & o_st_ready;
  wire take_sel = i_sel_valid & o_sel_ready;

  event_counter #(.W(16), .MAX(16'hffff), .SAT(1'b1)) u_err_cnt (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_inc(take_err), .o_count(err_cnt), .o_wrap());

  wire [2:0] err_ptr_d = (err_ptr_q == ERR_SLOTS || err_ptr_q == 3'h0) ? 3'h1 : err_ptr_q + 3'h1;
  wire [4:0] st_ptr_d = (st_ptr_q == ST_SLOTS || st_ptr_q == 5'h00) ? 5'h01 : st_ptr_q + 5'h01;
  wire [8:0] err_base_d = 9'(OFF_ERR_BASE + 9'(err_ptr_d - 3'h1) * ERR_ENTRY_LEN);
  wire [8:0] st_base_d = 9'(ST_DESC_BASE + 9'(st_ptr_d - 5'h01) * ST_DESC_LEN);

  // Monitoring command screening
  wire is_mon = i_cmd_valid & (i_cmd.command == MON_OPCODE);
  wire key_ok = ({i_cmd.cyl_hi, i_cmd.cyl_lo} == MON_KEY);
  wire sub_en = (i_cmd.features == SUB_ENABLE);
  wire sub_dis = (i_cmd.features == SUB_DISABLE);
  wire sub_ok = sub_en | sub_dis | i_sub_supported;
  wire reject = !key_ok | !sub_ok | (!mon_en_q & !sub_en);
  wire [7:0] resp_err = reject ? ERR_ABORT : i_attr_rd_fail ? ERR_TBL_RD :
                        i_attr_wr_fail ? ERR_TBL_WR : ERR_NONE;
  wire [7:0] resp_status = (resp_err == ERR_NONE) ? STATUS_OK : STATUS_FAIL;
  assign o_mon_enabled = mon_en_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_resp <= '0;
      mon_en_q <= 1'b1;
    end else begin
      o_resp <= '{valid: is_mon, status: resp_status, error: resp_err};
      if (is_mon && !reject && (sub_en || sub_dis)) begin
        mon_en_q <= sub_en;
      end
    end
  end

  // Command history, newest in slot 0
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < CMD_SLOTS; i++) begin
        hist_q[i] <= '0;
        ts_q[i] <= 32'h0000_0000;
      end
      state_q <= DST_UNKNOWN;
    end else if (i_cmd_valid) begin
      hist_q[0] <= i_cmd;
      ts_q[0] <= ms_cnt;
      for (int i = 1; i < CMD_SLOTS; i++) begin
        hist_q[i] <= hist_q[i-1];
        ts_q[i] <= ts_q[i-1];
      end
      state_q <= i_dev_state;
    end
  end

  // Byte image of the accepted job; counts and addresses least significant byte first, taskfile registers most significant field first
  always_comb begin
    for (int k = 0; k < JOB_BYTES; k++) begin
      pay_d[k] = 8'h00;
    end
    if (take_err) begin
      for (int s = 0; s < CMD_SLOTS; s++) begin
        for (int b = 0; b < 8; b++) begin
          pay_d[s*CMD_SNAP_LEN+b] = hist_q[CMD_SLOTS-1-s][63-8*b -: 8];
        end
        for (int b = 0; b < 4; b++) begin
          pay_d[s*CMD_SNAP_LEN+TS_OFF+b] = ts_q[CMD_SLOTS-1-s][8*b +: 8];
        end
      end
      for (int b = 1; b < 8; b++) begin
        pay_d[ERR_SNAP_OFF+b] = i_err[63-8*b -: 8];
      end
      pay_d[ERR_SNAP_OFF+STATE_OFF] = {4'h0, state_q};
      pay_d[ERR_SNAP_OFF+HOURS_OFF] = i_power_on_hours[7:0];
      pay_d[ERR_SNAP_OFF+HOURS_OFF+1] = i_power_on_hours[15:8];
      pay_d[90] = {5'h00, err_ptr_d};
      pay_d[91] = ERR_VERSION;
    end else if (take_st) begin
      pay_d[0] = i_st.number;
      pay_d[1] = i_st.status;
      pay_d[2] = i_st.hours[7:0];
      pay_d[3] = i_st.hours[15:8];
      pay_d[4] = i_st.checkpoint;
      for (int b = 0; b < 4; b++) begin
        pay_d[5+b] = i_st.lba[8*b +: 8];
      end
      pay_d[24] = {3'h0, st_ptr_d};
    end else begin
      for (int b = 0; b < 8; b++) begin
        pay_d[b] = i_sel_lba[8*b +: 8];
      end
      pay_d[8] = i_sel_span[7:0];
      pay_d[9] = i_sel_span[15:8];
    end
  end

  // Host access to the selective log
  wire [1:0] h_sec = i_addr[10:9];
  wire [8:0] h_off = i_addr[8:0];
  wire h_span = (h_off <= OFF_SEL_SPAN_END);
  wire h_misc = (h_off[8:1] == OFF_SEL_FLAGS[8:1]) | (h_off[8:1] == OFF_SEL_PEND[8:1]) | (h_off == OFF_CSUM);
  wire host_we = i_wr & (h_sec == SEC_SEL) & (h_span | h_misc);

  // Writer address and data
  wire job_run = (st_q != W_IDLE);
  wire [7:0] cnt_byte = idx_q[0] ? err_cnt[15:8] : err_cnt[7:0];
  wire [8:0] err_off = (idx_q < 11'(ERR_ENTRY_LEN)) ? 9'(base_q + idx_q[8:0]) :
                       (idx_q == 11'h05a) ? OFF_ERR_PTR :
                       (idx_q == 11'h05b) ? OFF_VER : 9'(OFF_ERR_CNT + {8'h00, idx_q[0]});
  wire [8:0] st_off = (idx_q == ST_JOB_LAST) ? OFF_ST_PTR : 9'(base_q + idx_q[8:0]);
  wire [8:0] sel_off = 9'(OFF_SEL_CUR + idx_q[8:0]);
  wire [7:0] clr_data = (idx_q == {SEC_ERR, OFF_VER}) ? ERR_VERSION :
                        (idx_q == {SEC_ST, OFF_VER}) ? ST_REVISION : 8'h00;
  wire [10:0] job_addr = (st_q == W_CLEAR) ? idx_q : (st_q == W_ERR) ? {SEC_ERR, err_off} :
                         (st_q == W_ST) ? {SEC_ST, st_off} : {SEC_SEL, sel_off};
  wire [7:0] job_data = (st_q == W_CLEAR) ? clr_data :
                        (st_q == W_ERR && idx_q > 11'h05b) ? cnt_byte : job_q[idx_q[6:0]];
  wire [10:0] job_last = (st_q == W_CLEAR) ? RAM_LAST : (st_q == W_ERR) ? ERR_JOB_LAST :
                         (st_q == W_ST) ? ST_JOB_LAST : SEL_JOB_LAST;
  wire job_we = job_run & !host_we;
  wire job_done = job_we & (idx_q == job_last);

  always_comb begin
    case (st_q)
      W_CLEAR, W_ERR, W_ST, W_SEL: st_d = job_done ? W_IDLE : st_q;
      W_IDLE: st_d = take_err ? W_ERR : take_st ? W_ST : take_sel ? W_SEL : W_IDLE;
      default: st_d = W_CLEAR;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= W_CLEAR;
      idx_q <= 11'h000;
      base_q <= 9'h000;
      err_ptr_q <= 3'h0;
      st_ptr_q <= 5'h00;
    end else begin
      st_q <= st_d;
      if (idle) begin
        idx_q <= 11'h000;
      end else if (job_we) begin
        idx_q <= idx_q + 11'h001;
      end
      if (take_err) begin
        err_ptr_q <= err_ptr_d;
        base_q <= err_base_d;
      end else if (take_st) begin
        st_ptr_q <= st_ptr_d;
        base_q <= st_base_d;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (idle) begin
      job_q <= pay_d;
    end
  end

  log_ram u_ram (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_we(host_we | job_we),
    .i_waddr(host_we ? i_addr : job_addr),
    .i_wdata(host_we ? i_wdata : job_data),
    .i_raddr_a(i_addr),
    .i_raddr_b(scan_q),
    .o_rdata_a(ram_a),
    .o_rdata_b(ram_b)
  );

  // Background checksum scan over the device-owned sectors
  wire [7:0] sum_in = (scan_prev_q == OFF_VER) ? ram_b : 8'(sum_q + ram_b);
  wire [7:0] csum_new = 8'(~sum_in + 8'h01);
  wire scan_sec = scan_q[9];

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scan_q <= 11'h000;
      scan_prev_q <= 9'h000;
      sum_q <= 8'h00;
      csum_q[0] <= 8'h00;
      csum_q[1] <= 8'h00;
    end else begin
      scan_q <= (scan_q == RAM_LAST) ? 11'h000 : scan_q + 11'h001;
      scan_prev_q <= scan_q[8:0];
      sum_q <= sum_in;
      if (scan_prev_q == OFF_CSUM_LAST && scan_q[10] == 1'b0) begin
        csum_q[scan_sec] <= csum_new;
      end
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_sec_q <= SEC_NONE;
      rd_csum_q <= 1'b0;
      rd_csum_val_q <= 8'h00;
    end else if (i_rd) begin
      rd_sec_q <= h_sec;
      rd_csum_q <= (h_off == OFF_CSUM) & !h_sec[1];
      rd_csum_val_q <= csum_q[h_sec[0]];
    end
  end

  assign o_rdata = (rd_sec_q == SEC_NONE) ? 8'h00 : rd_csum_q ? rd_csum_val_q : ram_a;
endmodule : drive_health_log_recorder
`default_nettype wire

// >>> verilog/health_log_pkg.sv
package health_log_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_TIME_NS / CLK_PERIOD_NS;
  // Memory map: {sector[1:0], offset[8:0]}
  localparam int unsigned RAM_DEPTH = 1536;
  localparam logic [10:0] RAM_LAST = 11'h05ff;
  localparam logic [1:0] SEC_ERR = 2'h0;
  localparam logic [1:0] SEC_ST = 2'h1;
  localparam logic [1:0] SEC_SEL = 2'h2;
  localparam logic [1:0] SEC_NONE = 2'h3;
  // Error log sector
  localparam logic [8:0] OFF_VER = 9'h000;
  localparam logic [8:0] OFF_ERR_PTR = 9'h001;
  localparam logic [8:0] OFF_ERR_BASE = 9'h002;
  localparam logic [8:0] ERR_ENTRY_LEN = 9'h05a;
  localparam logic [8:0] OFF_ERR_CNT = 9'h1c4;
  localparam logic [8:0] OFF_CSUM = 9'h1ff;
  localparam logic [8:0] OFF_CSUM_LAST = 9'h1fe;
  localparam logic [7:0] ERR_VERSION = 8'h01;
  localparam logic [2:0] ERR_SLOTS = 3'h5;
  localparam int unsigned CMD_SLOTS = 5;
  localparam int unsigned CMD_SNAP_LEN = 12;
  localparam int unsigned TS_OFF = 8;
  localparam int unsigned ERR_SNAP_OFF = 60;
  localparam int unsigned STATE_OFF = 27;
  localparam int unsigned HOURS_OFF = 28;
  // Self-test log sector
  localparam logic [8:0] ST_DESC_BASE = 9'h002;
  localparam logic [8:0] ST_DESC_LEN = 9'h018;
  localparam logic [8:0] OFF_ST_PTR = 9'h1fc;
  localparam logic [4:0] ST_SLOTS = 5'h15;
  localparam logic [7:0] ST_REVISION = 8'h01;
  // Selective self-test log sector
  localparam logic [8:0] OFF_SEL_SPAN_END = 9'h051;
  localparam logic [8:0] OFF_SEL_CUR = 9'h1ec;
  localparam logic [8:0] OFF_SEL_FLAGS = 9'h1f6;
  localparam logic [8:0] OFF_SEL_PEND = 9'h1fc;
  // Writer jobs: job buffer length, and last byte index of each
  localparam int unsigned JOB_BYTES = 94;
  localparam logic [10:0] ERR_JOB_LAST = 11'h05d;
  localparam logic [10:0] ST_JOB_LAST = 11'h018;
  localparam logic [10:0] SEL_JOB_LAST = 11'h009;
  // Answer codes
  localparam logic [7:0] STATUS_OK = 8'h50;
  localparam logic [7:0] STATUS_FAIL = 8'h51;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] ERR_TBL_RD = 8'h40;
  localparam logic [7:0] ERR_TBL_WR = 8'h10;
  // Device state codes
  localparam logic [3:0] DST_UNKNOWN = 4'h0;
  localparam logic [3:0] DST_SLEEP = 4'h1;
  localparam logic [3:0] DST_STANDBY = 4'h2;
  localparam logic [3:0] DST_ACTIVE = 4'h3;
  localparam logic [3:0] DST_SELFTEST = 4'h4;

  typedef struct packed {
    logic [7:0] devctl;
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] devhead;
    logic [7:0] command;
  } ata_cmd_t;

  typedef struct packed {
    logic [7:0] error;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] devhead;
    logic [7:0] status;
  } ata_err_t;

  typedef struct packed {
    logic [7:0] number;
    logic [7:0] status;
    logic [15:0] hours;
    logic [7:0] checkpoint;
    logic [31:0] lba;
  } st_result_t;

  typedef struct packed {
    logic valid;
    logic [7:0] status;
    logic [7:0] error;
  } mon_resp_t;

  typedef enum logic [4:0] {
    W_CLEAR = 5'b00001,
    W_IDLE = 5'b00010,
    W_ERR = 5'b00100,
    W_ST = 5'b01000,
    W_SEL = 5'b10000
  } wr_state_t;
endpackage : health_log_pkg

// >>> verilog/log_ram.sv
`timescale 1ns/10ps
`default_nettype none
module log_ram (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [10:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [10:0] i_raddr_a,
  input wire logic [10:0] i_raddr_b,
  output logic [7:0] o_rdata_a,
  output logic [7:0] o_rdata_b
);
  import health_log_pkg::*;
  logic [7:0] mem [0:RAM_DEPTH-1];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata_a <= 8'h00;
      o_rdata_b <= 8'h00;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end
endmodule : log_ram
`default_nettype wire

// >>> verilog/event_counter.sv
`timescale 1ns/10ps
`default_nettype none
module event_counter #(
  parameter int W = 16,
  parameter logic [W-1:0] MAX = '1,
  parameter bit SAT = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_inc,
  output logic [W-1:0] o_count,
  output logic o_wrap
);
  wire at_max = (o_count == MAX);
  assign o_wrap = i_inc & at_max & !SAT;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= '0;
    end else if (i_inc) begin
      if (!at_max) begin
        o_count <= o_count + 1'b1;
      end else if (!SAT) begin
        o_count <= '0;
      end
    end
  end
endmodule : event_counter
`default_nettype wire

// >>> bench/hlr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module hlr_monitor #(
  parameter logic [7:0] MON_OPCODE = 8'h01,
  parameter logic [15:0] MON_KEY = 16'h0001,
  parameter logic [7:0] SUB_ENABLE = 8'h01,
  parameter logic [7:0] SUB_DISABLE = 8'h02
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire health_log_pkg::ata_cmd_t i_cmd,
  input wire logic i_sub_supported,
  input wire logic i_attr_rd_fail,
  input wire logic i_attr_wr_fail,
  input wire health_log_pkg::mon_resp_t o_resp,
  input wire logic o_mon_enabled,
  input wire logic i_err_valid,
  input wire logic o_err_ready,
  input wire logic i_st_valid,
  input wire logic o_st_ready,
  input wire logic i_sel_valid,
  input wire logic o_sel_ready
);
  import health_log_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  logic mon;
  logic key_ok;
  logic sub_ok;
  logic live;
  logic ok;
  logic abt;
  assign mon = i_cmd_valid && i_cmd.command == MON_OPCODE;
  assign key_ok = {i_cmd.cyl_hi, i_cmd.cyl_lo} == MON_KEY;
  assign sub_ok = i_cmd.features == SUB_ENABLE || i_cmd.features == SUB_DISABLE || i_sub_supported;
  assign live = o_mon_enabled || i_cmd.features == SUB_ENABLE;
  assign ok = mon && key_ok && sub_ok && live;
  assign abt = o_resp.valid && o_resp.status == STATUS_FAIL && o_resp.error == ERR_ABORT;
  property p_no_key;
    mon && !key_ok |=> abt;
  endproperty
  a_no_key: assert property (p_no_key) else $error("missing key not aborted");
  property p_bad_sub;
    mon && key_ok && !sub_ok |=> abt;
  endproperty
  a_bad_sub: assert property (p_bad_sub) else $error("bad subcommand not aborted");
  property p_disabled;
    mon && key_ok && !live |=> abt;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled command not aborted");
  property p_rd_fail;
    ok && i_attr_rd_fail |=> o_resp.valid && o_resp.status == STATUS_FAIL && o_resp.error == ERR_TBL_RD;
  endproperty
  a_rd_fail: assert property (p_rd_fail) else $error("read failure answer wrong");
  property p_wr_fail;
    ok && !i_attr_rd_fail && i_attr_wr_fail |=> o_resp.status == STATUS_FAIL && o_resp.error == ERR_TBL_WR;
  endproperty
  a_wr_fail: assert property (p_wr_fail) else $error("write failure answer wrong");
  property p_no_spur;
    !mon |=> !o_resp.valid;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without command");
  property p_enable;
    ok && i_cmd.features == SUB_ENABLE |=> o_mon_enabled;
  endproperty
  a_enable: assert property (p_enable) else $error("enable not taken");
  property p_disable;
    ok && i_cmd.features == SUB_DISABLE |=> !o_mon_enabled;
  endproperty
  a_disable: assert property (p_disable) else $error("disable not taken");
  property p_err_busy;
    i_err_valid && o_err_ready |=> (!o_err_ready)[*8] ##86 !o_err_ready ##1 o_err_ready;
  endproperty
  a_err_busy: assert property (p_err_busy) else $error("error entry job length wrong");
  property p_st_busy;
    i_st_valid && o_st_ready |=> (!o_st_ready)[*8] ##17 !o_st_ready ##1 o_st_ready;
  endproperty
  a_st_busy: assert property (p_st_busy) else $error("descriptor job length wrong");
  property p_sel_busy;
    i_sel_valid && o_sel_ready |=> (!o_sel_ready)[*8] ##2 !o_sel_ready ##1 o_sel_ready;
  endproperty
  a_sel_busy: assert property (p_sel_busy) else $error("progress job length wrong");
  c_ok: cover property (ok);
  c_abort: cover property (mon && !key_ok);
  c_err: cover property (i_err_valid && o_err_ready);
  c_sel: cover property (i_sel_valid && o_sel_ready);
endmodule : hlr_monitor
bind drive_health_log_recorder hlr_monitor #(
  .MON_OPCODE(MON_OPCODE),
  .MON_KEY(MON_KEY),
  .SUB_ENABLE(SUB_ENABLE),
  .SUB_DISABLE(SUB_DISABLE)
) u_mon (
  .i_core_clk, .i_nrst, .i_cmd_valid, .i_cmd, .i_sub_supported, .i_attr_rd_fail, .i_attr_wr_fail,
  .o_resp, .o_mon_enabled, .i_err_valid, .o_err_ready, .i_st_valid, .o_st_ready, .i_sel_valid, .o_sel_ready
);
`default_nettype wire

// >>> bench/hlr_host.sv
`timescale 1ns/10ps
`default_nettype none
module hlr_host (
  input wire logic i_core_clk,
  output logic o_cmd_valid,
  output health_log_pkg::ata_cmd_t o_cmd,
  output logic [3:0] o_dev_state,
  output logic o_sup,
  output logic o_rd_fail,
  output logic o_wr_fail
);
  import health_log_pkg::*;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
    o_dev_state = DST_UNKNOWN;
    o_sup = 1'b0;
    o_rd_fail = 1'b0;
    o_wr_fail = 1'b0;
  end
  // One taskfile command; the bus shows the inverse once released
  task automatic send(input ata_cmd_t c, input logic [3:0] s, input logic [2:0] f);
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    o_dev_state <= s;
    {o_sup, o_rd_fail, o_wr_fail} <= f;
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b0;
    o_cmd <= ~c;
  endtask : send
endmodule : hlr_host
`default_nettype wire

// >>> bench/drive_health_log_recorder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module drive_health_log_recorder_tb;
  import health_log_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [10:0] i_addr = 11'h000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_err_valid = 1'b0;
  logic i_st_valid = 1'b0;
  logic i_sel_valid = 1'b0;
  ata_err_t i_err = '0;
  logic [15:0] i_power_on_hours = 16'h0000;
  st_result_t i_st = '0;
  logic [63:0] i_sel_lba = '0;
  logic [15:0] i_sel_span = 16'h0000;
  logic i_cmd_valid;
  ata_cmd_t i_cmd;
  logic [3:0] i_dev_state;
  logic i_sub_supported;
  logic i_attr_rd_fail;
  logic i_attr_wr_fail;
  logic [7:0] o_rdata;
  mon_resp_t o_resp;
  logic o_mon_enabled;
  logic o_err_ready;
  logic o_st_ready;
  logic o_sel_ready;
  logic [2:0] rdys;
  int miscompares = 0;
  int n_checks = 0;
  logic [10:0] sa [8] = '{11'h402, 11'h451, 11'h452, 11'h5f6, 11'h5fd, 11'h5ff, 11'h600, 11'h5ec};
  logic [7:0] sw [8] = '{8'h5a, 8'hc3, 8'hff, 8'h11, 8'h22, 8'h33, 8'hff, 8'hff};
  logic [7:0] sx [8] = '{8'h5a, 8'hc3, 8'h00, 8'h11, 8'h22, 8'h33, 8'h00, 8'h08};
  assign rdys = {o_sel_ready, o_st_ready, o_err_ready};
  always #2 i_core_clk = ~i_core_clk;
  drive_health_log_recorder #(.CYCLES_PER_MS(10)) DUT (
    .i_core_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_cmd_valid, .i_cmd, .i_dev_state,
    .i_sub_supported, .i_attr_rd_fail, .i_attr_wr_fail, .o_resp, .o_mon_enabled, .i_err_valid, .i_err,
    .i_power_on_hours, .o_err_ready, .i_st_valid, .i_st, .o_st_ready, .i_sel_valid, .i_sel_lba,
    .i_sel_span, .o_sel_ready
  );
  hlr_host u_host (
    .i_core_clk, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_dev_state(i_dev_state),
    .o_sup(i_sub_supported), .o_rd_fail(i_attr_rd_fail), .o_wr_fail(i_attr_wr_fail)
  );
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic rd8(input logic [10:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd8
  task automatic rdc(input logic [10:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd8(a, d);
    chk8(d, e);
  endtask : rdc
  task automatic wr8(input logic [10:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr8
  task automatic waitr(input int k);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(negedge i_core_clk);
      if (rdys[k] === 1'b1) break;
    end
    if (i == 2000) begin
      miscompares++;
      $display("MISMATCH t=%0t ready timeout", $time);
      summarize();
    end
  endtask : waitr
  task automatic ev(input int k);
    @(posedge i_core_clk);
    case (k)
      0: i_err_valid <= 1'b1;
      1: i_st_valid <= 1'b1;
      default: i_sel_valid <= 1'b1;
    endcase
    waitr(k);
    @(posedge i_core_clk);
    i_err_valid <= 1'b0;
    i_st_valid <= 1'b0;
    i_sel_valid <= 1'b0;
    waitr(k);
  endtask : ev
  task automatic mcmd(input logic [7:0] ft, input logic [15:0] key, input logic [2:0] f,
                      input logic [7:0] es, input logic [7:0] ee);
    ata_cmd_t c;
    c = '{8'h00, ft, 8'h00, 8'h00, key[7:0], key[15:8], 8'ha0, 8'h01};
    u_host.send(c, DST_ACTIVE, f);
    #1;
    chk8({7'h00, o_resp.valid}, 8'h01);
    chk8(o_resp.status, es);
    chk8(o_resp.error, ee);
  endtask : mcmd
  initial begin : main
    int j;
    int k;
    logic [7:0] d;
    logic [7:0] sum;
    ata_cmd_t c;
    repeat (4) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    mcmd(8'h08, 16'h0000, 3'b100, 8'h51, 8'h04);
    mcmd(8'h08, 16'h0001, 3'b000, 8'h51, 8'h04);
    mcmd(8'h08, 16'h0001, 3'b110, 8'h51, 8'h40);
    mcmd(8'h08, 16'h0001, 3'b101, 8'h51, 8'h10);
    mcmd(8'h08, 16'h0001, 3'b100, 8'h50, 8'h00);
    mcmd(8'h02, 16'h0001, 3'b100, 8'h50, 8'h00);
    chk8({7'h00, o_mon_enabled}, 8'h00);
    mcmd(8'h08, 16'h0001, 3'b100, 8'h51, 8'h04);
    mcmd(8'h01, 16'h0001, 3'b000, 8'h50, 8'h00);
    chk8({7'h00, o_mon_enabled}, 8'h01);
    $display("test commands done");
    for (j = 0; j < 5; j++) begin
      c = '{8'h00, 8'h10 + 8'(j), 8'h01, 8'h02, 8'h03, 8'h04, 8'he0, 8'hc0 + 8'(j)};
      u_host.send(c, DST_STANDBY, 3'b100);
    end
    i_err <= '{8'h04, 8'h11, 8'h22, 8'h33, 8'h44, 8'he0, 8'h51};
    i_power_on_hours <= 16'h1234;
    waitr(0);
    for (j = 0; j < 6; j++) begin
      ev(0);
      rdc(11'h001, 8'(j % 5 + 1));
    end
    for (j = 0; j < 5; j++) begin
      rdc(11'(3 + 12 * j), 8'h10 + 8'(j));
      rdc(11'(9 + 12 * j), 8'hc0 + 8'(j));
    end
    rdc(11'h00d, 8'h00);
    rdc(11'h03e, 8'h00);
    rdc(11'h03f, 8'h04);
    rdc(11'h045, 8'h51);
    rdc(11'h059, 8'h02);
    rdc(11'h05a, 8'h34);
    rdc(11'h05b, 8'h12);
    rdc(11'h1c4, 8'h06);
    rdc(11'h1c5, 8'h00);
    $display("test error log done");
    rdc(11'h3fc, 8'h00);
    for (j = 0; j < 22; j++) begin
      @(posedge i_core_clk);
      i_st <= '{8'h30 + 8'(j), 8'h07, 16'h0100 + 16'(j), 8'h0a, 32'ha1b2_c300 + 32'(j)};
      ev(1);
      rdc(11'h3fc, 8'(j % 21 + 1));
    end
    rdc(11'h202, 8'h45);
    rdc(11'h3e2, 8'h44);
    rdc(11'h21a, 8'h31);
    rdc(11'h21b, 8'h07);
    rdc(11'h21c, 8'h01);
    rdc(11'h21d, 8'h01);
    rdc(11'h21e, 8'h0a);
    rdc(11'h21f, 8'h01);
    rdc(11'h222, 8'ha1);
    rdc(11'h223, 8'h00);
    $display("test self-test log done");
    @(posedge i_core_clk);
    i_sel_lba <= 64'h0102_0304_0506_0708;
    i_sel_span <= 16'h0003;
    ev(2);
    for (j = 0; j < 8; j++) wr8(sa[j], sw[j]);
    for (j = 0; j < 8; j++) rdc(sa[j], sx[j]);
    rdc(11'h5f3, 8'h01);
    rdc(11'h5f4, 8'h03);
    rdc(11'h5f5, 8'h00);
    $display("test selective log done");
    repeat (3200) @(posedge i_core_clk);
    for (k = 0; k < 2; k++) begin
      sum = 8'h00;
      for (j = 0; j < 511; j++) begin
        rd8(11'(k * 512 + j), d);
        sum = sum + d;
      end
      rd8(11'(k * 512 + 511), d);
      chk8(sum + d, 8'h00);
    end
    $display("test checksum done");
    summarize();
  end
endmodule : drive_health_log_recorder_tb
`default_nettype wire
